/* pkg/diag_params.svh */
`ifndef DIAG_PARAMS_SVH
`define DIAG_PARAMS_SVH

// ----------------------------------------
// Object indices
// ----------------------------------------
`define IDX_CFG_LIST   16'hF020
`define IDX_DET_LIST   16'hF040
`define IDX_DIAG       16'hF101
`define IDX_COND       16'hF102

// ----------------------------------------
// List limits
// ----------------------------------------
`define CFG_LIST_DEPTH 127
`define DET_LIST_DEPTH 126
`define MAX_SLAVES     8'h7E
`define SUB_LIST_LAST  8'h7F

// ----------------------------------------
// Diagnostic word subindices
// ----------------------------------------
`define SUB_COUNT      8'h00
`define SUB_GAP_LO     8'h01
`define SUB_GAP_MID    8'h09
`define SUB_SYNC_TGL   8'h0C
`define SUB_DEV_DIAG   8'h0D
`define SUB_SYNC_ERR   8'h0E
`define SUB_IN_TGL     8'h0F
`define SUB_FAULT      8'h10
`define SUB_CYC_CNT    8'h11
`define SUB_SLV_CNT    8'h12
`define SUB_GAP_HI     8'h13
`define SUB_CYC_TIME   8'h14

// ----------------------------------------
// Diagnostic word bit positions
// ----------------------------------------
`define BIT_SYNC_TGL   11
`define BIT_IN_TGL     14
`define BIT_FAULT      15
`define POS_CYC_CNT    16
`define POS_SLV_CNT    32
`define POS_CYC_TIME   48

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_WORD16     16'h0000
`define RST_WORD64     64'h0000_0000_0000_0000

`endif

/* pkg/diag_pkg.sv */
package diag_pkg;

    // Slave condition codes
    typedef enum logic [7:0] {
        COND_OK          = 8'h00,
        COND_NO_RESTART  = 8'h01,  // [RULE11]
        COND_NO_RESPONSE = 8'h02,  // [RULE11]
        COND_SDO_LEN     = 8'h04,  // [RULE12]
        COND_SDO_VAL     = 8'h05,  // [RULE12]
        COND_BOOT        = 8'h08,  // [RULE13]
        COND_BUS_OFF     = 8'h0B,  // [RULE14]
        COND_LEFT_OP     = 8'h0C,  // [RULE15]
        COND_GUARD       = 8'h0E,  // [RULE16]
        COND_WAIT_HOST   = 8'h12,  // [RULE17]
        COND_PDO_LEN     = 8'h14,  // [RULE18]
        COND_PDO_LATE    = 8'h16,  // [RULE19]
        COND_PDO_MISSING = 8'h17,  // [RULE20]
        COND_TX_OVF      = 8'h18,  // [RULE21]
        COND_TYPE1_MISS  = 8'h28   // [RULE22]
    } cond_t;

    // CAN cycle timing states
    typedef enum logic [1:0] {
        CYC_IDLE = 2'b01,
        CYC_RUN  = 2'b10
    } cyc_state_t;

endpackage

/* rtl/node_list.sv */
`timescale 1ns/1ns
`include "diag_params.svh"
module node_list #(
    parameter int DEPTH = `CFG_LIST_DEPTH
) (
    input  logic        i_clk,
    input  logic        i_rst_n,
    input  logic        i_clear,
    input  logic        i_push,
    input  logic [6:0]  i_addr,
    input  logic [6:0]  i_sel,
    output logic [7:0]  o_count,
    output logic [15:0] o_sel_addr
);
    if (DEPTH < 1 || DEPTH > 127) begin : g_chk
        $error("node_list DEPTH out of range");
    end

    typedef struct packed {
        logic [7:0]                  count;
        logic [DEPTH-1:0][6:0]       addr;
    } list_state_t;

    list_state_t s_r;
    list_state_t s_nxt;
    logic [6:0]  sel_idx;

    always_comb begin
        s_nxt = s_r;
        if (i_clear) begin
            s_nxt.count = 8'h00;
        end else if (i_push && s_r.count < 8'(DEPTH)) begin
            s_nxt.addr[s_r.count[6:0]] = i_addr;
            s_nxt.count = s_r.count + 8'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Entries past the count read as zero
    assign sel_idx    = i_sel - 7'h01;
    assign o_count    = s_r.count;
    assign o_sel_addr = (i_sel != 7'h00 && {1'b0, i_sel} <= s_r.count)
                        ? {9'h000, s_r.addr[sel_idx]} : `RST_WORD16;
endmodule

/* rtl/cond_table.sv */
`timescale 1ns/1ns
`include "diag_params.svh"
module cond_table
    import diag_pkg::*;
#(
    parameter int DEPTH = `CFG_LIST_DEPTH
) (
    input  logic        i_clk,
    input  logic        i_rst_n,
    input  logic        i_clear,
    input  logic        i_wr,
    input  logic [6:0]  i_slot,
    input  cond_t       i_code,
    input  logic [7:0]  i_active,
    input  logic        i_bus_off,
    input  logic [6:0]  i_sel,
    output logic [7:0]  o_sel_code,
    output logic [7:0]  o_fault_cnt
);
    if (DEPTH < 1 || DEPTH > 127) begin : g_chk
        $error("cond_table DEPTH out of range");
    end

    typedef struct packed {
        logic [DEPTH-1:0][7:0] code;
    } cond_state_t;

    cond_state_t s_r;
    cond_state_t s_nxt;
    logic [6:0]  wr_idx;
    logic [6:0]  sel_idx;
    logic        boot_ok;

    assign wr_idx  = i_slot - 7'h01;
    assign sel_idx = i_sel - 7'h01;
    assign boot_ok = s_r.code[wr_idx] == COND_OK || s_r.code[wr_idx] == COND_BOOT;

    always_comb begin
        s_nxt = s_r;
        if (i_clear) begin
            s_nxt = '0;
        end else if (i_wr && i_slot != 7'h00 && {1'b0, i_slot} <= i_active) begin
            // Boot-up only shows while no error is held
            if (i_code != COND_BOOT || boot_ok) begin  // [RULE13]
                s_nxt.code[wr_idx] = i_code;  // [RULE10] [RULE11] [RULE12]
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        o_fault_cnt = 8'h00;
        for (int k = 0; k < DEPTH; k++) begin
            if (8'(k) < i_active && (s_r.code[k] != COND_OK || i_bus_off)) begin
                o_fault_cnt = o_fault_cnt + 8'h01;
            end
        end
        o_sel_code = 8'h00;
        if (i_sel != 7'h00 && {1'b0, i_sel} <= i_active) begin
            o_sel_code = i_bus_off ? COND_BUS_OFF : s_r.code[sel_idx];  // [RULE14]
        end
    end

    property p_boot_blocked;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_wr && !i_clear && i_code == COND_BOOT && !boot_ok
            |=> s_r.code[$past(wr_idx)] == $past(s_r.code[wr_idx]);
    endproperty
    a_boot_blocked: assert property (p_boot_blocked) else $error("boot over error"); // [RULE13]
endmodule

/* rtl/canopen_diag_bank.sv */
// Operation
// RULE1 - Configured list subindex zero gives count
// RULE2 - Interface first at node zero, 126 slaves
// RULE3 - Configured entries read 16-bit node addresses
// RULE4 - Scan fills detected list with count
// RULE5 - Sync toggle flips per sent SYNC
// RULE6 - Input toggle flips on refreshed input update
// RULE7 - Fault bit set while any code nonzero
// RULE8 - Cycle counter counts cycles when slaves exist
// RULE9 - Cycle time field holds last tick count
// RULE10 - One 8-bit code per configured slave
// RULE11 - Codes 0, 1, 2 for ok, unrestarted, silent
// RULE12 - Codes 4, 5 for startup transfer faults
// RULE13 - Code 8 during error-free boot-up
// RULE14 - Code 11 while controller is bus-off
// RULE15 - Code 12 after leaving operational state
// RULE16 - Code 14 when guarding toggle fails
// RULE17 - Code 18 when waiting for host exchange
// RULE18 - Code 20 on wrong-length transmit object
// RULE19 - Code 22 on late transmit object
// RULE20 - Code 23 while objects still missing
// RULE21 - Code 24 on transmit queue overflow
// RULE22 - Code 40 on missed type-1 object
// RULE23 - Reserved fields read zero, writes ignored
`timescale 1ns/1ns
`include "diag_params.svh"
module canopen_diag_bank
    import diag_pkg::*;
#(
    parameter int CFG_DEPTH = `CFG_LIST_DEPTH,
    parameter int DET_DEPTH = `DET_LIST_DEPTH
) (
    input  logic        i_clk,
    input  logic        i_rst_n,
    input  logic        i_cfg_clear,
    input  logic        i_cfg_push,
    input  logic        i_cfg_iface,
    input  logic [6:0]  i_cfg_node,
    input  logic        i_scan_start,
    input  logic        i_scan_found,
    input  logic [6:0]  i_scan_node,
    input  logic        i_cond_wr,
    input  logic [6:0]  i_cond_slot,
    input  cond_t       i_cond_code,
    input  logic        i_bus_off,
    input  logic        i_sync_sent,
    input  logic        i_in_refreshed,
    input  logic        i_in_update,
    input  logic        i_cycle_start,
    input  logic        i_cycle_done,
    input  logic        i_rd_en,
    input  logic [15:0] i_rd_index,
    input  logic [7:0]  i_rd_sub,
    output logic        o_rd_valid,
    output logic [15:0] o_rd_data,
    output logic        o_rd_err,
    output logic [63:0] o_diag_word
);
    if (CFG_DEPTH < 1 || CFG_DEPTH > 127 || DET_DEPTH < 1 || DET_DEPTH > 126) begin : g_chk
        $error("list depth out of range");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic        iface;
        logic        sync_tgl;
        logic        in_tgl;
        logic        in_pending;
        logic [15:0] cyc_cnt;
        logic [15:0] tick_cnt;
        logic [15:0] cyc_time;
        cyc_state_t  cyc_st;
        logic        rd_valid;
        logic        rd_err;
        logic [15:0] rd_data;
        logic [63:0] diag_word;
    } bank_state_t;

    bank_state_t s_r;
    bank_state_t s_nxt;

    logic [7:0]  cfg_cnt;
    logic [7:0]  det_cnt;
    logic [7:0]  slave_cnt;
    logic [15:0] cfg_sel_addr;
    logic [15:0] det_sel_addr;
    logic [7:0]  sel_code;
    logic [7:0]  fault_cnt;
    logic        fault_bit;
    logic        cfg_ok;
    logic [6:0]  cfg_node;

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    function automatic logic [15:0] zext8(input logic [7:0] v);
        return {8'h00, v};
    endfunction

    // ----------------------------------------
    // Lists and condition codes
    // ----------------------------------------
    assign slave_cnt = cfg_cnt - {7'h00, s_r.iface};
    assign cfg_ok    = i_cfg_push && !i_cfg_clear &&
                       (i_cfg_iface ? (cfg_cnt == 8'h00)                // [RULE2]
                                    : (slave_cnt < `MAX_SLAVES));       // [RULE2]
    assign cfg_node  = i_cfg_iface ? 7'h00 : i_cfg_node;                 // [RULE2]
    assign fault_bit = fault_cnt != 8'h00;                               // [RULE7]

    node_list #(.DEPTH(CFG_DEPTH)) u_cfg (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_clear    (i_cfg_clear),
        .i_push     (cfg_ok),
        .i_addr     (cfg_node),
        .i_sel      (i_rd_sub[6:0]),
        .o_count    (cfg_cnt),
        .o_sel_addr (cfg_sel_addr)
    );

    node_list #(.DEPTH(DET_DEPTH)) u_det (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_clear    (i_scan_start),
        .i_push     (i_scan_found && !i_scan_start),  // [RULE4]
        .i_addr     (i_scan_node),
        .i_sel      (i_rd_sub[6:0]),
        .o_count    (det_cnt),
        .o_sel_addr (det_sel_addr)
    );

    cond_table #(.DEPTH(CFG_DEPTH)) u_cond (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_clear     (i_cfg_clear),
        .i_wr        (i_cond_wr),
        .i_slot      (i_cond_slot),
        .i_code      (i_cond_code),
        .i_active    (cfg_cnt),
        .i_bus_off   (i_bus_off),
        .i_sel       (i_rd_sub[6:0]),
        .o_sel_code  (sel_code),
        .o_fault_cnt (fault_cnt)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.rd_valid = 1'b0;
        s_nxt.rd_err   = 1'b0;
        s_nxt.rd_data  = `RST_WORD16;

        if (i_cfg_clear) begin
            s_nxt.iface = 1'b0;
        end else if (cfg_ok && i_cfg_iface) begin
            s_nxt.iface = 1'b1;
        end

        if (i_sync_sent) begin
            s_nxt.sync_tgl = ~s_r.sync_tgl;  // [RULE5]
        end

        // A refresh arriving with the update is counted, not lost
        if (i_in_update) begin
            if (s_r.in_pending || i_in_refreshed) begin
                s_nxt.in_tgl = ~s_r.in_tgl;  // [RULE6]
            end
            s_nxt.in_pending = 1'b0;
        end else if (i_in_refreshed) begin
            s_nxt.in_pending = 1'b1;
        end

        if (i_cycle_done && slave_cnt != 8'h00) begin
            s_nxt.cyc_cnt = s_r.cyc_cnt + 16'h0001;  // [RULE8]
        end

        case (s_r.cyc_st)
            CYC_IDLE: begin
                if (i_cycle_start) begin
                    s_nxt.cyc_st   = CYC_RUN;
                    s_nxt.tick_cnt = `RST_WORD16;
                end
            end
            CYC_RUN: begin
                if (i_cycle_done) begin
                    s_nxt.cyc_time = sat_inc(s_r.tick_cnt);  // [RULE9]
                    s_nxt.tick_cnt = `RST_WORD16;
                    s_nxt.cyc_st   = i_cycle_start ? CYC_RUN : CYC_IDLE;
                end else begin
                    s_nxt.tick_cnt = sat_inc(s_r.tick_cnt);
                end
            end
            default: begin
                s_nxt.cyc_st = CYC_IDLE;
            end
        endcase

        // Object read port
        if (i_rd_en) begin
            s_nxt.rd_valid = 1'b1;
            case (i_rd_index)
                `IDX_CFG_LIST: begin
                    if (i_rd_sub == `SUB_COUNT) begin
                        s_nxt.rd_data = zext8(cfg_cnt);  // [RULE1]
                    end else if (i_rd_sub <= `SUB_LIST_LAST) begin
                        s_nxt.rd_data = cfg_sel_addr;    // [RULE3]
                    end else begin
                        s_nxt.rd_err = 1'b1;
                    end
                end
                `IDX_DET_LIST: begin
                    if (i_rd_sub == `SUB_COUNT) begin
                        s_nxt.rd_data = zext8(det_cnt);  // [RULE4]
                    end else if (i_rd_sub < `SUB_LIST_LAST) begin
                        s_nxt.rd_data = det_sel_addr;    // [RULE4]
                    end else begin
                        s_nxt.rd_err = 1'b1;
                    end
                end
                `IDX_DIAG: begin
                    case (i_rd_sub)
                        `SUB_COUNT:    s_nxt.rd_data = zext8(`SUB_CYC_TIME);
                        `SUB_GAP_LO,
                        `SUB_GAP_MID,
                        `SUB_DEV_DIAG,
                        `SUB_SYNC_ERR,
                        `SUB_GAP_HI:   s_nxt.rd_data = `RST_WORD16;  // [RULE23]
                        `SUB_SYNC_TGL: s_nxt.rd_data = {15'h0000, s_r.sync_tgl};
                        `SUB_IN_TGL:   s_nxt.rd_data = {15'h0000, s_r.in_tgl};
                        `SUB_FAULT:    s_nxt.rd_data = {15'h0000, fault_bit};
                        `SUB_CYC_CNT:  s_nxt.rd_data = s_r.cyc_cnt;
                        `SUB_SLV_CNT:  s_nxt.rd_data = zext8(fault_cnt);
                        `SUB_CYC_TIME: s_nxt.rd_data = s_r.cyc_time;
                        default:       s_nxt.rd_err  = 1'b1;
                    endcase
                end
                `IDX_COND: begin
                    if (i_rd_sub == `SUB_COUNT) begin
                        s_nxt.rd_data = zext8(cfg_cnt);
                    end else if (i_rd_sub <= `SUB_LIST_LAST) begin
                        s_nxt.rd_data = zext8(sel_code);  // [RULE10] [RULE14]
                    end else begin
                        s_nxt.rd_err = 1'b1;
                    end
                end
                default: begin
                    s_nxt.rd_err = 1'b1;
                end
            endcase
        end

        // Packed word, reserved bits held at zero
        s_nxt.diag_word = {s_nxt.cyc_time, 8'h00, fault_cnt, s_nxt.cyc_cnt,
                           fault_bit, s_nxt.in_tgl, 2'b00, s_nxt.sync_tgl,
                           11'h000};  // [RULE23] [RULE7]
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r        <= '0;
            s_r.cyc_st <= CYC_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rd_valid  = s_r.rd_valid;
    assign o_rd_data   = s_r.rd_data;
    assign o_rd_err    = s_r.rd_err;
    assign o_diag_word = s_r.diag_word;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_cfg_count;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_rd_en && i_rd_index == `IDX_CFG_LIST && i_rd_sub == `SUB_COUNT
            |=> o_rd_valid && !o_rd_err && o_rd_data == {8'h00, $past(cfg_cnt)};
    endproperty
    a_cfg_count: assert property (p_cfg_count) else $error("bad count"); // [RULE1]

    property p_slave_max;
        @(posedge i_clk) disable iff (!i_rst_n)
        slave_cnt <= `MAX_SLAVES && (!s_r.iface || cfg_cnt != 8'h00);
    endproperty
    a_slave_max: assert property (p_slave_max) else $error("too many slaves"); // [RULE2]

    property p_cfg_entry;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_rd_en && i_rd_index == `IDX_CFG_LIST && i_rd_sub != `SUB_COUNT
            && i_rd_sub <= `SUB_LIST_LAST |=> o_rd_data == $past(cfg_sel_addr);
    endproperty
    a_cfg_entry: assert property (p_cfg_entry) else $error("bad entry"); // [RULE3]

    property p_sync_tgl;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_sync_sent |=> o_diag_word[`BIT_SYNC_TGL] != $past(o_diag_word[`BIT_SYNC_TGL]);
    endproperty
    a_sync_tgl: assert property (p_sync_tgl) else $error("sync toggle"); // [RULE5]

    property p_in_tgl;
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_in_update |=> $stable(o_diag_word[`BIT_IN_TGL]);
    endproperty
    a_in_tgl: assert property (p_in_tgl) else $error("input toggle"); // [RULE6]

    property p_fault;
        @(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |=> o_diag_word[`BIT_FAULT] == ($past(fault_cnt) != 8'h00);
    endproperty
    a_fault: assert property (p_fault) else $error("fault bit"); // [RULE7]

    property p_cyc_cnt;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_cycle_done && slave_cnt != 8'h00
            |=> o_diag_word[31:16] == $past(o_diag_word[31:16]) + 16'h0001;
    endproperty
    a_cyc_cnt: assert property (p_cyc_cnt) else $error("cycle count"); // [RULE8]

    property p_cyc_time;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_cycle_start && s_r.cyc_st == CYC_IDLE ##1 !i_cycle_done [*2] ##1 i_cycle_done
            |=> o_diag_word[63:48] == 16'h0003;
    endproperty
    a_cyc_time: assert property (p_cyc_time) else $error("cycle time"); // [RULE9]

    property p_bus_off;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_rd_en && i_bus_off && i_rd_index == `IDX_COND && i_rd_sub != `SUB_COUNT
            && i_rd_sub <= {1'b0, cfg_cnt[6:0]} && cfg_cnt != 8'h00
            |=> o_rd_data == 16'h000B;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus-off code"); // [RULE14]

    property p_reserved;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_rd_en && i_rd_index == `IDX_DIAG && i_rd_sub == `SUB_DEV_DIAG
            |=> o_rd_data == 16'h0000 && !o_rd_err;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved nonzero"); // [RULE23]

    c_bad_index: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_rd_err);
    c_fault:     cover property (@(posedge i_clk) disable iff (!i_rst_n)
                                 o_diag_word[`BIT_FAULT]);
    c_cycle:     cover property (@(posedge i_clk) disable iff (!i_rst_n)
                                 i_cycle_done && s_r.cyc_st == CYC_RUN);
endmodule

/* verif/slave_node_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Far-side CAN cycle source
// ----------------------------------------
module slave_node_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_go,
    input  wire logic [15:0] i_len,
    output logic             o_cycle_start,
    output logic             o_cycle_done,
    output logic             o_sync_sent
);
    int cnt;

    // Cycle opens with one SYNC, closes i_len ticks later
    always @(negedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cycle_start <= 1'b0;
            o_cycle_done  <= 1'b0;
            o_sync_sent   <= 1'b0;
            cnt           <= 0;
        end else begin
            o_cycle_start <= 1'b0;
            o_cycle_done  <= 1'b0;
            o_sync_sent   <= 1'b0;
            if (cnt == 0 && i_go) begin
                o_cycle_start <= 1'b1;
                o_sync_sent   <= 1'b1;
                cnt           <= int'(i_len);
            end else if (cnt == 1) begin
                o_cycle_done <= 1'b1;
                cnt          <= 0;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    import diag_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  ev = 8'h00;
    logic        iface = 1'b0;
    logic        bus_off = 1'b0;
    logic        go = 1'b0;
    logic [6:0]  node = 7'h00;
    logic [6:0]  slot = 7'h00;
    cond_t       code = COND_OK;
    logic [15:0] len = 16'h0005;
    logic        rd_en = 1'b0;
    logic [15:0] idx = 16'h0000;
    logic [7:0]  sub = 8'h00;
    logic        cyc_start, cyc_done, sync_sent, rd_valid, rd_err;
    logic [15:0] rd_data;
    logic [63:0] diag;
    logic        exp_sync = 1'b0;
    logic [15:0] exp_cnt = 16'h0000;
    logic [7:0]  codes [14] = '{8'h00, 8'h08, 8'h01, 8'h02, 8'h04, 8'h05, 8'h0C,
                                8'h0E, 8'h12, 8'h14, 8'h16, 8'h17, 8'h18, 8'h28};
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #20 clk = ~clk;

    canopen_diag_bank i_canopen_diag_bank (
        .i_clk(clk), .i_rst_n(rst_n), .i_cfg_clear(ev[0]), .i_cfg_push(ev[1]),
        .i_cfg_iface(iface), .i_cfg_node(node), .i_scan_start(ev[2]),
        .i_scan_found(ev[3]), .i_scan_node(node), .i_cond_wr(ev[4]),
        .i_cond_slot(slot), .i_cond_code(code), .i_bus_off(bus_off),
        .i_sync_sent(sync_sent), .i_in_refreshed(ev[6]), .i_in_update(ev[7]),
        .i_cycle_start(cyc_start), .i_cycle_done(cyc_done), .i_rd_en(rd_en),
        .i_rd_index(idx), .i_rd_sub(sub), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data), .o_rd_err(rd_err), .o_diag_word(diag));

    slave_node_model i_slave_node_model (
        .i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_len(len),
        .o_cycle_start(cyc_start), .o_cycle_done(cyc_done), .o_sync_sent(sync_sent));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic pulse(input logic [7:0] m);
        @(negedge clk);
        ev = m;
        @(negedge clk);
        ev = 8'h00;
    endtask

    task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [15:0] exp,
                      input logic err);
        @(negedge clk);
        rd_en = 1'b1;
        idx = i;
        sub = s;
        @(negedge clk);
        rd_en = 1'b0;
        chk("rd_valid", 64'h1, {63'h0, rd_valid});
        chk("rd_err", {63'h0, err}, {63'h0, rd_err});
        chk($sformatf("object %h:%h", i, s), {48'h0, exp}, {48'h0, rd_data});
    endtask

    task automatic can_cycle(input logic [15:0] n, input logic slaves);
        int k;
        len = n;
        @(negedge clk);
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        for (k = 0; k < 100 && cyc_done !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        exp_sync = ~exp_sync;
        if (slaves) exp_cnt = exp_cnt + 16'h0001;
        chk("cycle time", {48'h0, n}, {48'h0, diag[63:48]});
        chk("cycle counter", {48'h0, exp_cnt}, {48'h0, diag[31:16]});
        chk("sync toggle", {63'h0, exp_sync}, {63'h0, diag[11]});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_config;
        pulse(8'h01);
        iface = 1'b1;
        pulse(8'h02);
        iface = 1'b0;
        node = 7'h05;
        pulse(8'h02);
        node = 7'h09;
        pulse(8'h02);
        iface = 1'b1;
        pulse(8'h02);
        iface = 1'b0;
        rd(16'hF020, 8'h00, 16'h0003, 1'b0);
        rd(16'hF020, 8'h01, 16'h0000, 1'b0);
        rd(16'hF020, 8'h02, 16'h0005, 1'b0);
        rd(16'hF020, 8'h03, 16'h0009, 1'b0);
        rd(16'hF020, 8'h7F, 16'h0000, 1'b0);
        rd(16'hF020, 8'h80, 16'h0000, 1'b1);
    endtask

    task automatic t_scan;
        pulse(8'h04);
        node = 7'h03;
        pulse(8'h08);
        node = 7'h07;
        pulse(8'h08);
        rd(16'hF040, 8'h00, 16'h0002, 1'b0);
        rd(16'hF040, 8'h02, 16'h0007, 1'b0);
        rd(16'hF040, 8'h7F, 16'h0000, 1'b1);
    endtask

    task automatic t_codes;
        int k;
        slot = 7'h02;
        for (k = 0; k < 14; k++) begin
            code = cond_t'(codes[k]);
            pulse(8'h10);
            rd(16'hF102, 8'h02, {8'h00, codes[k]}, 1'b0);
            chk("fault bit", {63'h0, codes[k] != 8'h00}, {63'h0, diag[15]});
        end
        code = COND_BOOT;
        pulse(8'h10);
        rd(16'hF102, 8'h02, 16'h0028, 1'b0);
        bus_off = 1'b1;
        rd(16'hF102, 8'h03, 16'h000B, 1'b0);
        chk("fault bit", 64'h1, {63'h0, diag[15]});
        chk("faulty count", 64'h3, {56'h0, diag[39:32]});
        bus_off = 1'b0;
        code = COND_OK;
        pulse(8'h10);
        rd(16'hF102, 8'h02, 16'h0000, 1'b0);
        chk("fault bit", 64'h0, {63'h0, diag[15]});
    endtask

    task automatic t_toggles;
        pulse(8'h80);
        @(negedge clk);
        chk("input toggle", 64'h0, {63'h0, diag[14]});
        pulse(8'h40);
        pulse(8'h80);
        @(negedge clk);
        chk("input toggle", 64'h1, {63'h0, diag[14]});
        pulse(8'hC0);
        @(negedge clk);
        chk("input toggle", 64'h0, {63'h0, diag[14]});
    endtask

    task automatic t_reserved;
        rd(16'hF101, 8'h00, 16'h0014, 1'b0);
        rd(16'hF101, 8'h01, 16'h0000, 1'b0);
        rd(16'hF101, 8'h0D, 16'h0000, 1'b0);
        rd(16'hF101, 8'h0E, 16'h0000, 1'b0);
        rd(16'hF101, 8'h05, 16'h0000, 1'b1);
        rd(16'hF101, 8'h15, 16'h0000, 1'b1);
        rd(16'h1234, 8'h00, 16'h0000, 1'b1);
        rd(16'hF101, 8'h0C, {15'h0, exp_sync}, 1'b0);
        rd(16'hF101, 8'h11, exp_cnt, 1'b0);
        rd(16'hF101, 8'h14, 16'h0002, 1'b0);
        rd(16'hF101, 8'h0F, 16'h0000, 1'b0);
        rd(16'hF101, 8'h10, 16'h0000, 1'b0);
        rd(16'hF101, 8'h12, 16'h0000, 1'b0);
        chk("reserved low bits", 64'h0, {51'h0, diag[13:12], diag[10:0]});
        chk("reserved gap", 64'h0, {56'h0, diag[47:40]});
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles >= 5000) begin
            num_errors++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        chk("diag word", 64'h0, diag);
        t_config;
        t_scan;
        t_codes;
        t_toggles;
        can_cycle(16'h0005, 1'b1);
        can_cycle(16'h0002, 1'b1);
        t_reserved;
        pulse(8'h01);
        iface = 1'b1;
        pulse(8'h02);
        can_cycle(16'h0003, 1'b0);
        tally_and_finish;
    end
endmodule
